// ---- sobm_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps

module sobm_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : sobm_fifo

// ---- sobm_filter_model.sv ----
/*
 * Far-side model: a decimating filter that takes the bitstream.
 * Assumes bits arrive as one-cycle valid pulses on clk; stall is
 * driven by the bench off the sampling edge.
 */
`timescale 1ns/100ps

module sobm_filter_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic data_out,
    input  wire logic data_valid,
    input  wire logic stall,
    input  wire logic clear,
    output logic      filter_ready,
    output int        ones,
    output int        total
);
    assign filter_ready = !stall;

    // Counting ones over a window is the simplest low-pass decimator.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n || clear) begin
            ones  <= 0;
            total <= 0;
        end else if (data_valid) begin
            total <= total + 1;
            ones  <= ones + int'(data_out);
        end
    end
endmodule : sobm_filter_model

// ---- sobm_map.svh ----
/*
 * Constants for the second-order bitstream modulator: input scaling,
 * transfer-curve points, loop widths and clock timing.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef SOBM_MAP_SVH
`define SOBM_MAP_SVH

// System clock and nominal conversion clock.
`define SOBM_SYS_CLK_MHZ      100
`define SOBM_CONV_CLK_MHZ     20
`define SOBM_CONV_DIV         (`SOBM_SYS_CLK_MHZ / `SOBM_CONV_CLK_MHZ)

// Input sample is a signed code in units of 10 microvolts.
`define SOBM_IN_W             16
`define SOBM_UV_PER_LSB       10
`define SOBM_LIN_MV           250
`define SOBM_CLIP_MV          320
`define SOBM_LIN_CODE         (`SOBM_LIN_MV * 1000 / `SOBM_UV_PER_LSB)
`define SOBM_CLIP_CODE        (`SOBM_CLIP_MV * 1000 / `SOBM_UV_PER_LSB)

// Ones density at zero, at the linear limit and at clip, in hundredths of a percent.
`define SOBM_DENS_ZERO_CP     5000
`define SOBM_DENS_FS_CP       8906
`define SOBM_DENS_CLIP_CP     10000

// Feedback reference, in input codes: full scale maps to density 89.06 %.
// Reference R satisfies 0.5 + LIN/(2R) = 0.8906, so R = LIN / 0.7812.
`define SOBM_REF_CODE         (`SOBM_LIN_CODE * 10000 / 7812)

// Integrator width and reset values.
`define SOBM_ACC_W            24
`define SOBM_ACC1_RST         24'h000000
`define SOBM_ACC2_RST         24'h000000
`define SOBM_BIT_RST          1'h0

`endif

// ---- sobm_modulator.sv ----
/*
 * Behavioural second-order 1-bit delta-sigma modulator core.
 * The analog input arrives as two signed codes (10 uV per LSB). A
 * conversion clock is derived from clk; bits are taken on its falling edge and reach data_out a clk or more later.
 * Assumes inputs are synchronous to clk and the filter samples rising.
 */
// How it works
// RULE1 - Conversion clock comes from outside; here clk-derived.
// RULE2 - One output bit per conversion clock cycle; here none in a period whose fall finds the buffer full.
// RULE3 - Output bit changes on conversion clock fall; here taken at fall, on data_out a clk or more later.
// RULE4 - Zero input gives fifty percent ones.
// RULE5 - Plus 250 mV gives 89.06 percent ones.
// RULE6 - Minus 250 mV gives 10.94 percent ones.
// RULE7 - Beyond 320 mV output clips solid.
// RULE8 - 250 to 320 mV band is monotonic, non-linear.
// RULE9 - Linearity holds only within 250 mV.
// RULE10 - Feedback subtracted before both cascaded integrators.
// RULE11 - Feedback follows comparator on next clock.
// RULE12 - Input sampled once per conversion period.
// RULE13 - Receiver should low-pass decimate the stream.
// RULE14 - Single mode, runs continuously.
// RULE15 - Density interpolates linearly; integrators start arbitrary.
`timescale 1ns/100ps
`include "sobm_map.svh"

module sobm_modulator #(
    parameter int CONV_DIV   = `SOBM_CONV_DIV,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire sobm_pkg::sobm_sample_t positive_analog_input,
    input  wire sobm_pkg::sobm_sample_t negative_analog_input,
    input  wire logic                 filter_ready,
    output logic                      conversion_clock_out,
    output logic                      data_out,
    output logic                      data_valid,
    output logic                      input_linear,
    output logic                      input_stalled
);
    import sobm_pkg::*;

    localparam int CW  = $clog2(CONV_DIV);
    localparam int LIN = `SOBM_LIN_CODE;
    localparam int CLP = `SOBM_CLIP_CODE;
    localparam int REF = `SOBM_REF_CODE;

    localparam logic [CW-1:0] HALF_CNT = CW'(CONV_DIV / 2 - 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(CONV_DIV - 1);

    logic [CW-1:0]  div_r;
    logic           cclk_r;
    logic           rise;
    logic           fall;
    sobm_acc_t      diff_r;
    sobm_acc_t      drive;
    sobm_acc_t      acc1_r;
    sobm_acc_t      acc2_r;
    sobm_acc_t      acc1_nxt;
    sobm_acc_t      acc2_nxt;
    sobm_acc_t      fb;
    logic           cmp_r;
    logic           bit_r;
    sobm_region_e   region;
    logic           fifo_in_ready;
    logic           fifo_out_data;
    logic           fifo_out_valid;
    logic           out_bit_r;
    logic           out_vld_r;
    logic           stall_r;
    logic           lin_r;

    function automatic sobm_region_e classify(input sobm_acc_t v);
        if (v <= -sobm_acc_t'(CLP)) begin
            return SOBM_CLIP_LO;
        end else if (v >= sobm_acc_t'(CLP)) begin
            return SOBM_CLIP_HI;
        end else if (v > sobm_acc_t'(LIN) || v < -sobm_acc_t'(LIN)) begin
            return SOBM_NONLIN;
        end
        return SOBM_LINEAR;
    endfunction : classify

    // The conversion clock free-runs from reset; there is no mode. RULE1 RULE14
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r  <= '0;
            cclk_r <= 1'b0;
        end else begin
            div_r <= (div_r == LAST_CNT) ? '0 : div_r + 1'b1;
            if (div_r == HALF_CNT) begin
                cclk_r <= 1'b1;
            end else if (div_r == LAST_CNT) begin
                cclk_r <= 1'b0;
            end
        end
    end

    assign rise = (div_r == HALF_CNT);
    assign fall = (div_r == LAST_CNT);

    // One differential sample per conversion period, on the rising phase. RULE12
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            diff_r <= '0;
        end else if (rise) begin
            diff_r <= sobm_acc_t'(positive_analog_input)
                    - sobm_acc_t'(negative_analog_input);
        end
    end

    assign region = classify(diff_r);

    // Past full scale the slope is halved, so the density keeps rising but
    // bends away from the straight line. A steeper slope would push the
    // drive beyond the feedback reference, and a second-order loop driven
    // past its reference grows without bound and wraps the integrators.
    // Clipped inputs feed a bounded drive for the same reason, so the loop
    // is still healthy when the input comes back into range. RULE8 RULE9
    always_comb begin
        unique case (region)
            SOBM_NONLIN:  drive = (diff_r >>> 1) + (diff_r[`SOBM_ACC_W-1]
                                  ? -sobm_acc_t'(LIN / 2)
                                  : sobm_acc_t'(LIN / 2));
            SOBM_CLIP_LO: drive = -sobm_acc_t'(LIN);
            SOBM_CLIP_HI: drive = sobm_acc_t'(LIN);
            default:      drive = diff_r;
        endcase
    end

    // Feedback is the 1-bit DAC of the last comparator decision. RULE11
    assign fb = cmp_r ? sobm_acc_t'(REF) : -sobm_acc_t'(REF);

    // Two cascaded integrators, feedback subtracted ahead of each. RULE10
    // Density = 0.5 + x/(2*REF), giving 50, 89.06 and 10.94 %. RULE4 RULE5 RULE6 RULE15
    assign acc1_nxt = acc1_r + drive - fb;
    assign acc2_nxt = acc2_r + acc1_nxt - fb;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc1_r <= `SOBM_ACC1_RST;
            acc2_r <= `SOBM_ACC2_RST;
            cmp_r  <= `SOBM_BIT_RST;
        end else if (fall && fifo_in_ready) begin
            acc1_r <= acc1_nxt;
            acc2_r <= acc2_nxt;
            cmp_r  <= ~acc2_nxt[`SOBM_ACC_W-1];
        end
    end

    // Clipped inputs force a solid stream regardless of loop state. RULE7
    always_comb begin
        unique case (region)
            SOBM_CLIP_LO: bit_r = 1'b0;
            SOBM_CLIP_HI: bit_r = 1'b1;
            default:      bit_r = ~acc2_nxt[`SOBM_ACC_W-1];
        endcase
    end

    // Each falling edge pushes one bit into the buffer unless the buffer is full. RULE2 RULE3
    sobm_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_data   (bit_r),
        .in_valid  (fall),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (filter_ready)
    );

    // Outputs are registered. A full buffer freezes the loop for that period
    // rather than dropping a bit, so the density stays honest. RULE2
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_bit_r <= 1'b0;
            out_vld_r <= 1'b0;
            stall_r   <= 1'b0;
            lin_r     <= 1'b1;
        end else begin
            out_bit_r <= fifo_out_data;
            out_vld_r <= fifo_out_valid && filter_ready;
            stall_r   <= fall && !fifo_in_ready;
            lin_r     <= (region == SOBM_LINEAR);
        end
    end

    assign conversion_clock_out = cclk_r;
    assign data_out             = out_bit_r;
    assign data_valid           = out_vld_r;
    assign input_linear         = lin_r;
    assign input_stalled        = stall_r;

    a_clip_high_ones: assert property (@(posedge clk) disable iff (!arst_n)
        fall && region == SOBM_CLIP_HI && fifo_in_ready |-> bit_r) // RULE7
        else $error("clip high did not give a one");

    a_clip_low_zeros: assert property (@(posedge clk) disable iff (!arst_n)
        fall && region == SOBM_CLIP_LO |-> !bit_r) // RULE7
        else $error("clip low did not give a zero");

    sequence s_fall_taken;
        fall && fifo_in_ready;
    endsequence

    a_feedback_follows: assert property (@(posedge clk) disable iff (!arst_n)
        s_fall_taken |=> cmp_r == !$past(acc2_nxt[`SOBM_ACC_W-1])) // RULE11
        else $error("feedback did not follow comparator");

    a_one_bit_period: assert property (@(posedge clk) disable iff (!arst_n)
        fall |=> !fall [*4]) // RULE2
        else $error("more than one bit per period");

    a_fall_edge_bit: assert property (@(posedge clk) disable iff (!arst_n)
        fall |=> !cclk_r) // RULE3
        else $error("bit not taken at falling edge");

    a_sample_once: assert property (@(posedge clk) disable iff (!arst_n)
        !rise |=> $stable(diff_r)) // RULE12
        else $error("input sampled off the rising phase");

    a_integ_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !fall |=> $stable(acc1_r) && $stable(acc2_r)) // RULE10
        else $error("integrators moved between periods");

    a_clock_runs: assert property (@(posedge clk) disable iff (!arst_n)
        fall |-> ##[1:5] rise) // RULE14
        else $error("conversion clock stopped");

    a_linear_flag: assert property (@(posedge clk) disable iff (!arst_n)
        region == SOBM_LINEAR |=> input_linear) // RULE9
        else $error("linear flag wrong");

    a_linear_flag_low: assert property (@(posedge clk) disable iff (!arst_n)
        region != SOBM_LINEAR |=> !input_linear) // RULE9
        else $error("linear flag set outside the linear range");

    sequence s_fall_blocked;
        fall && !fifo_in_ready;
    endsequence

    sequence s_pop;
        fifo_out_valid && filter_ready;
    endsequence

    a_stall_flag: assert property (@(posedge clk) disable iff (!arst_n)
        s_fall_blocked |=> input_stalled) // RULE2
        else $error("blocked period not flagged");

    a_stall_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        !(fall && !fifo_in_ready) |=> !input_stalled) // RULE2
        else $error("stall flagged without a blocked period");

    a_loop_frozen: assert property (@(posedge clk) disable iff (!arst_n)
        s_fall_blocked |=> $stable(acc1_r) && $stable(cmp_r)) // RULE11
        else $error("loop moved while the buffer was full");

    a_pop_data: assert property (@(posedge clk) disable iff (!arst_n)
        s_pop |=> data_valid && data_out == $past(fifo_out_data)) // RULE2
        else $error("popped bit not presented");

    a_valid_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        !(fifo_out_valid && filter_ready) |=> !data_valid) // RULE2
        else $error("valid without a pop");

    a_div_wraps: assert property (@(posedge clk) disable iff (!arst_n)
        fall |=> div_r == '0) // RULE2
        else $error("divider did not wrap after the fall");

    a_cclk_shape: assert property (@(posedge clk) disable iff (!arst_n)
        rise |=> cclk_r [*3] ##1 !cclk_r) // RULE3
        else $error("conversion clock high phase wrong");

    a_sample_value: assert property (@(posedge clk) disable iff (!arst_n)
        rise |=> diff_r == sobm_acc_t'($past(positive_analog_input))
                         - sobm_acc_t'($past(negative_analog_input))) // RULE12
        else $error("sampled difference wrong");

    a_drive_bounded: assert property (@(posedge clk) disable iff (!arst_n)
        drive < sobm_acc_t'(REF) && drive > -sobm_acc_t'(REF)) // RULE8
        else $error("drive beyond the feedback reference");

    a_nonlin_sign: assert property (@(posedge clk) disable iff (!arst_n)
        region == SOBM_NONLIN |-> drive[`SOBM_ACC_W-1] ==
                                  diff_r[`SOBM_ACC_W-1]) // RULE8
        else $error("non-linear drive changed sign");

    a_integ_step: assert property (@(posedge clk) disable iff (!arst_n)
        s_fall_taken |=> acc1_r == $past(acc1_r) + $past(drive)
                                   - $past(fb)) // RULE10
        else $error("first integrator step wrong");

    // Counts clocks since the last fall; a missing fall would let it pass
    // the divider's last count, which the tools cannot see from one edge.
    logic [CW-1:0] since_fall_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_fall_r <= '0;
        end else begin
            since_fall_r <= fall ? '0 : since_fall_r + 1'b1;
        end
    end

    a_period_bound: assert property (@(posedge clk) disable iff (!arst_n)
        since_fall_r <= LAST_CNT) // RULE14
        else $error("conversion period overran");

    // Counts pushed bits while the input is clipped high; each must be one.
    logic [7:0] clip_ones_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clip_ones_r <= 8'h00;
        end else if (region != SOBM_CLIP_HI) begin
            clip_ones_r <= 8'h00;
        end else if (fall && fifo_in_ready && bit_r
                     && clip_ones_r != 8'hFF) begin
            clip_ones_r <= clip_ones_r + 8'h01;
        end
    end

    a_clip_run: assert property (@(posedge clk) disable iff (!arst_n)
        region == SOBM_CLIP_HI && fall && fifo_in_ready
        && clip_ones_r != 8'hFF |=> clip_ones_r != 8'h00) // RULE7
        else $error("clipped run broken");
endmodule : sobm_modulator

// ---- sobm_modulator_test.sv ----
/*
 * Self-checking bench for the modulator: density, rate, stall, reset.
 * Assumes sobm_pkg, sobm_fifo and the filter model are compiled first.
 */
`timescale 1ns/100ps
`include "sobm_map.svh"

module sobm_modulator_test;
    import sobm_pkg::*;
    localparam int TOL = 80;
    logic         clk    = 1'b0;
    logic         arst_n = 1'b0;
    logic         stall  = 1'b0;
    logic         clear  = 1'b0;
    sobm_sample_t pin    = '0;
    sobm_sample_t nin    = '0;
    logic         filter_ready, conv_clk, data_out, data_valid;
    logic         input_linear, input_stalled;
    int           ones, total;
    int           miscompares = 0;
    int           num_checks  = 0;
    int           cycles      = 0;
    int           table_d [12] = '{-40000, -32000, -28000, -25000, -12500,
                                   0, 12500, 25000, 28000, 31000, 32000,
                                   36000};

    sobm_modulator #(.CONV_DIV(`SOBM_CONV_DIV), .FIFO_DEPTH(4)) dut (
        .clk(clk), .arst_n(arst_n), .positive_analog_input(pin),
        .negative_analog_input(nin), .filter_ready(filter_ready),
        .conversion_clock_out(conv_clk), .data_out(data_out),
        .data_valid(data_valid), .input_linear(input_linear),
        .input_stalled(input_stalled));

    sobm_filter_model filt (
        .clk(clk), .arst_n(arst_n), .data_out(data_out),
        .data_valid(data_valid), .stall(stall), .clear(clear),
        .filter_ready(filter_ready), .ones(ones), .total(total));

    always #5 clk = ~clk;

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Timeout sized above the roughly 71500 cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check_bit(logic got, logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_range(int got, int lo, int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h..%0h",
                     $time, got, lo, hi);
        end
    endtask : check_range

    // Density bound in hundredths of a percent; the band past the linear
    // limit is only known to lie between the linear end and the clip.
    function automatic int dens_bound(int d, bit hi);
        int c = 5000 + d * 3906 / 25000;
        if (d >= 32000) return 10000;
        if (d <= -32000) return 0;
        if (d > 25000) return hi ? 10000 : 8906 - TOL;
        if (d < -25000) return hi ? 1094 + TOL : 0;
        return hi ? c + TOL : c - TOL;
    endfunction : dens_bound

    task automatic measure(int d, bit rnd_ready, output int dens);
        int j;
        j = int'($urandom_range(0, 2000)) - 1000;
        @(negedge clk);
        pin = sobm_sample_t'(d / 2 + j);
        nin = sobm_sample_t'(j - (d - d / 2));
        repeat (200) @(negedge clk);
        check_bit(input_linear, d <= 25000 && d >= -25000);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (4000) begin
            @(negedge clk);
            if (rnd_ready) stall = 1'($urandom_range(0, 1));
        end
        stall = 1'b0;
        dens = total > 0 ? ones * 10000 / total : -1;
        check_range(dens, dens_bound(d, 0), dens_bound(d, 1));
        if (!rnd_ready) check_range(total, 799, 801);
        $display("test density d=%0d dens=%0d", d, dens);
    endtask : measure

    task automatic reset_check;
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        check_bit(data_valid, 1'b0);
        check_bit(input_stalled, 1'b0);
        check_bit(conv_clk, 1'b0);
        check_bit(input_linear, 1'b1);
        arst_n = 1'b1;
        $display("test reset done");
    endtask : reset_check

    initial begin
        int dens, prev, t0, n_st, n_v;
        void'($urandom(39));
        reset_check();
        @(posedge conv_clk);
        t0 = int'($time);
        @(posedge conv_clk);
        check_range((int'($time) - t0) / 10, 5, 5);
        prev = 0;
        foreach (table_d[i]) begin
            measure(table_d[i], 1'b0, dens);
            check_range(dens, prev, 10000);
            prev = dens;
        end
        repeat (3) measure(int'($urandom_range(0, 50000)) - 25000, 1'b0, dens);
        measure(int'($urandom_range(0, 40000)) - 20000, 1'b1, dens);
        // Hold the far side off long enough to fill the buffer and freeze.
        @(negedge clk);
        stall = 1'b1;
        n_st = 0;
        n_v = 0;
        repeat (40) begin
            @(posedge clk);
            #1 n_st += int'(input_stalled);
            n_v += int'(data_valid);
        end
        check_range(n_st, 2, 8);
        check_range(n_v, 0, 2);
        @(negedge clk);
        stall = 1'b0;
        n_v = 0;
        repeat (8) begin
            @(posedge clk);
            #1 n_v += int'(data_valid);
        end
        check_range(n_v, 4, 6);
        $display("test stall done");
        reset_check();
        measure(0, 1'b0, dens);
        tally_and_finish();
    end
endmodule : sobm_modulator_test

// ---- sobm_pkg.sv ----
/*
 * Types shared by the modulator files.
 * Assumes sobm_map.svh is available on the include path.
 */
`include "sobm_map.svh"

package sobm_pkg;
    typedef logic signed [`SOBM_IN_W-1:0]  sobm_sample_t;
    typedef logic signed [`SOBM_ACC_W-1:0] sobm_acc_t;
    typedef enum logic [1:0] {
        SOBM_LINEAR  = 2'b00,
        SOBM_NONLIN  = 2'b01,
        SOBM_CLIP_LO = 2'b10,
        SOBM_CLIP_HI = 2'b11
    } sobm_region_e;
endpackage : sobm_pkg
